// File: rtl/vic_pkg.sv
// constants and types shared by the vectored interrupt controller
package vic_pkg;
	localparam int          VIC_NREQ        = 8;
	localparam int          VIC_FETCH_LEN   = 3;
	localparam logic [7:0]  VIC_LBR_OPCODE  = 8'hC0;
	localparam logic [7:0]  VIC_PAGE_RST    = 8'h00;
	localparam logic [7:0]  VIC_CTRL_RST    = 8'h00;
	localparam logic [7:0]  VIC_MASK_RST    = 8'h00;
	localparam logic [7:0]  VIC_DOUT_RST    = 8'h00;
	localparam logic [7:0]  VIC_REQ_IDLE    = 8'hFF;
	localparam logic [7:0]  VIC_PEND_RST    = 8'h00;
	localparam logic [7:0]  VIC_ZERO_BYTE   = 8'h00;
	localparam logic [7:0]  VIC_ONE_HOT0    = 8'h01;
	localparam logic [2:0]  VIC_NUM_RST     = 3'h0;
	// control byte field positions
	localparam int          VIC_CTRL_MIRQ   = 3;
	localparam int          VIC_CTRL_MMASK  = 2;
	localparam int          VIC_CTRL_IVL_HI = 1;
	localparam int          VIC_CTRL_IVL_LO = 0;

	// register select code, {select_addr_x, select_addr_y}
	typedef enum logic [1:0] {
		VIC_SEL_STAT = 2'b00,
		VIC_SEL_POLL = 2'b01,
		VIC_SEL_VECT = 2'b10,
		VIC_SEL_NONE = 2'b11
	} vic_sel_t;

	typedef enum logic [1:0] {
		VIC_IVL_2  = 2'b00,
		VIC_IVL_4  = 2'b01,
		VIC_IVL_8  = 2'b10,
		VIC_IVL_16 = 2'b11
	} vic_ivl_t;

	typedef enum logic [1:0] {
		VIC_BUS_IDLE = 2'b00,
		VIC_BUS_SEL  = 2'b01,
		VIC_BUS_RD   = 2'b10
	} vic_bus_t;

	typedef enum logic [1:0] {
		VIC_FB_OP = 2'b00,
		VIC_FB_HI = 2'b01,
		VIC_FB_LO = 2'b10
	} vic_fb_t;
endpackage : vic_pkg

// File: rtl/vic_core_if.sv
// internal carrier between the bus core, the request latches and the vector builder
`timescale 1ns/10ps
`default_nettype none
interface vic_core_if;
	logic [7:0] req_n;
	logic [7:0] pending;
	logic [7:0] clr_one;
	logic       clr_all;
	logic [7:0] mask;
	logic [7:0] ctrl;
	logic [7:0] low_byte;
	logic [2:0] num;
	logic       active;

	modport latch  (input req_n, clr_one, clr_all, output pending);
	modport vector (input pending, mask, ctrl, output low_byte, num, active);
	modport core   (output req_n, clr_one, clr_all, mask, ctrl,
	                input pending, low_byte, num, active);
endinterface : vic_core_if
`default_nettype wire

// File: rtl/vic_latch.sv
// falling-edge request latches, one per request input
`timescale 1ns/10ps
`default_nettype none
module vic_latch (
	input  wire logic clk,
	input  wire logic nrst,
	vic_core_if.latch lp
);
	logic [7:0] prev_ff;
	logic [7:0] pend_ff;

	assign lp.pending = pend_ff;

	genvar i;
	generate
		for (i = 0; i < vic_pkg::VIC_NREQ; i++) begin : g_req
			logic fall;
			logic clr;
			logic nxt_pend;
			assign fall     = prev_ff[i] & ~lp.req_n[i];
			assign clr      = lp.clr_all | lp.clr_one[i];
			// a new edge in the clearing cycle is kept
			assign nxt_pend = fall | (pend_ff[i] & ~clr);

			always_ff @(posedge clk) begin
				if (!nrst) begin
					prev_ff[i] <= vic_pkg::VIC_REQ_IDLE[i];
					pend_ff[i] <= vic_pkg::VIC_PEND_RST[i];
				end else begin
					prev_ff[i] <= lp.req_n[i];
					pend_ff[i] <= nxt_pend;
				end
			end

			a_fall_sets: assert property (@(posedge clk) disable iff (!nrst)
				fall |=> pend_ff[i]) else $error("falling request edge not latched");
			a_clear_drops: assert property (@(posedge clk) disable iff (!nrst)
				(clr && !fall) |=> !pend_ff[i]) else $error("pending latch not cleared");
		end
	endgenerate
endmodule : vic_latch
`default_nettype wire

// File: rtl/vic_vector.sv
// fixed-priority select and low vector byte builder
`timescale 1ns/10ps
`default_nettype none
module vic_vector (
	input  wire logic  clk,
	input  wire logic  nrst,
	vic_core_if.vector vp
);
	logic [7:0]      eff;
	logic [2:0]      num;
	logic [7:0]      low;
	vic_pkg::vic_ivl_t ivl;
	logic [2:0]      wgt;

	assign eff       = vp.pending & ~vp.mask;
	assign ivl       = vic_pkg::vic_ivl_t'(vp.ctrl[vic_pkg::VIC_CTRL_IVL_HI:vic_pkg::VIC_CTRL_IVL_LO]);
	assign vp.active = |eff;
	assign vp.num    = num;
	assign vp.low_byte = low;
	// bit index of the number field, counted apart from the slicing below
	assign wgt       = 3'(vp.ctrl[vic_pkg::VIC_CTRL_IVL_HI:vic_pkg::VIC_CTRL_IVL_LO]) + 3'h1;

	// later index wins, so input 7 is the highest
	always_comb begin
		num = vic_pkg::VIC_NUM_RST;
		for (int k = 0; k < vic_pkg::VIC_NREQ; k++) begin
			if (eff[k]) begin
				num = 3'(k);
			end
		end
	end

	// request number sits at the weight of the interval, below it zeros
	always_comb begin
		case (ivl)
			vic_pkg::VIC_IVL_2:  low = {vp.ctrl[7:4], num, 1'b0};
			vic_pkg::VIC_IVL_4:  low = {vp.ctrl[7:5], num, 2'b00};
			vic_pkg::VIC_IVL_8:  low = {vp.ctrl[7:6], num, 3'b000};
			vic_pkg::VIC_IVL_16: low = {vp.ctrl[7], num, 4'b0000};
			default:             low = {vp.ctrl[7:4], num, 1'b0};
		endcase
	end

	a_prio_top: assert property (@(posedge clk) disable iff (!nrst)
		eff[7] |-> (num == 3'h7)) else $error("input 7 not chosen first");
	a_ctrl_top: assert property (@(posedge clk) disable iff (!nrst)
		(((low >> wgt) & 8'h07) == {5'h00, num}) &&
		((low & ~(8'hFF << wgt)) == 8'h00) &&
		((low >> (wgt + 3'h3)) == (vp.ctrl >> (wgt + 3'h3))))
		else $error("low vector byte fields misplaced");
endmodule : vic_vector
`default_nettype wire

// File: rtl/vic_top.sv
// bus core of the eight-input vectored interrupt controller
// Function
// - a write-only page byte gives vector bits 15..8 for every request.
// - control bits 7..4 supply the programmed part of the low vector byte.
// - control bits 3..0 hold master interrupt reset, master mask reset, interval.
// - the interval decides how many control bits 7..4 reach the low byte.
// - low vector bits not from control hold the active request number, with zeros below it.
// - a one in the mask byte masks that request; chaining is never masked.
// - the status byte shows every pending request, masked or not.
// - the polling byte returns the low vector byte.
// - an interrupt fetch returns three bytes in consecutive reads; none are driven if the chaining input is low at the opcode byte.
// - the first fetch byte is the long-branch opcode C0.
// - the second fetch byte is the page byte unchanged.
// - the third byte is control bits plus the active request number.
// - access happens only when all chip selects are valid at the first pulse.
// - read with code x=1 y=0 returns branch and highest unmasked vector.
// - write with code x=1 y=0 loads the page byte.
// - write with code x=0 y=1 loads the control byte.
// - code 00 writes mask and reads status; code 11 does nothing.
// - read with code x=0 y=1 returns the polling byte.
// - chaining input takes a higher controller's interrupt; it takes precedence.
`timescale 1ns/10ps
`default_nettype none
module vic_top (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [7:0] request_inputs_n,
	input  wire logic       chain_in_n,
	input  wire logic       first_timing_pulse,
	input  wire logic       second_timing_pulse,
	input  wire logic       chip_sel,
	input  wire logic       chip_sel_n,
	input  wire logic       select_addr_x,
	input  wire logic       select_addr_y,
	input  wire logic       mem_read_strobe_n,
	input  wire logic       mem_write_strobe_n,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe_n,
	output logic            int_n
);
	vic_core_if cif ();

	logic                pulse_a_ff;
	logic                pulse_b_ff;
	vic_pkg::vic_bus_t   bus_ff;
	vic_pkg::vic_bus_t   nxt_bus;
	vic_pkg::vic_sel_t   code_ff;
	vic_pkg::vic_fb_t    fidx_ff;
	vic_pkg::vic_fb_t    nxt_fidx;
	logic                resp_ff;
	logic                hit_ff;
	logic [7:0]          page_ff;
	logic [7:0]          ctrl_ff;
	logic [7:0]          mask_ff;
	logic [7:0]          vec_lo_ff;
	logic [2:0]          vec_num_ff;
	logic [7:0]          data_out_ff;
	logic                oe_n_ff;
	logic                int_n_ff;
	logic                nxt_int_n;

	logic                pulse_a_fall;
	logic                pulse_b_rise;
	logic                cs_ok;
	vic_pkg::vic_sel_t   code_live;
	logic                in_sel;
	logic                rd_take;
	logic                wr_take;
	logic                rd_done;
	logic                fetch_take;
	logic                fetch_done;
	logic                fetch_last;
	logic                take_resp;
	logic                rd_drive;
	logic                wr_page;
	logic                wr_ctrl;
	logic                wr_mask;
	logic [7:0]          fetch_byte;
	logic [7:0]          rd_mux;

	// edges of the host timing pulses
	assign pulse_a_fall = pulse_a_ff & ~first_timing_pulse;
	assign pulse_b_rise = second_timing_pulse & ~pulse_b_ff;
	// select lines double as chip selects while the first pulse is up
	assign cs_ok      = chip_sel & ~chip_sel_n & select_addr_x & select_addr_y;
	assign code_live  = vic_pkg::vic_sel_t'({select_addr_x, select_addr_y});
	assign in_sel     = (bus_ff == vic_pkg::VIC_BUS_SEL);
	assign rd_take    = in_sel & pulse_b_rise & ~mem_read_strobe_n;
	assign wr_take    = in_sel & pulse_b_rise & ~mem_write_strobe_n & mem_read_strobe_n;
	assign rd_done    = (bus_ff == vic_pkg::VIC_BUS_RD) & mem_read_strobe_n;
	assign fetch_take = rd_take & (code_live == vic_pkg::VIC_SEL_VECT);
	assign fetch_done = rd_done & (code_ff == vic_pkg::VIC_SEL_VECT);
	assign fetch_last = fetch_done & (fidx_ff == vic_pkg::VIC_FB_LO);

	// decision to answer is made on the opcode byte and kept for the sequence
	assign take_resp  = (fidx_ff == vic_pkg::VIC_FB_OP) ? chain_in_n : resp_ff;
	assign rd_drive   = (code_live != vic_pkg::VIC_SEL_NONE) &
	                    ((code_live != vic_pkg::VIC_SEL_VECT) | take_resp);

	assign wr_page    = wr_take & (code_live == vic_pkg::VIC_SEL_VECT);
	assign wr_ctrl    = wr_take & (code_live == vic_pkg::VIC_SEL_POLL);
	assign wr_mask    = wr_take & (code_live == vic_pkg::VIC_SEL_STAT);

	// master mask reset lets all requests through without losing the mask
	assign cif.mask    = mask_ff & {8{ctrl_ff[vic_pkg::VIC_CTRL_MMASK]}};
	assign cif.ctrl    = ctrl_ff;
	assign cif.req_n   = request_inputs_n;
	assign cif.clr_all = rd_done & (code_ff == vic_pkg::VIC_SEL_STAT);
	assign cif.clr_one = (fetch_last & resp_ff & hit_ff) ?
	                     (vic_pkg::VIC_ONE_HOT0 << vec_num_ff) : vic_pkg::VIC_ZERO_BYTE;

	vic_latch u_latch (
		.clk  (clk),
		.nrst (nrst),
		.lp   (cif.latch)
	);

	vic_vector u_vector (
		.clk  (clk),
		.nrst (nrst),
		.vp   (cif.vector)
	);

	always_comb begin
		case (fidx_ff)
			vic_pkg::VIC_FB_OP: fetch_byte = vic_pkg::VIC_LBR_OPCODE;
			vic_pkg::VIC_FB_HI: fetch_byte = page_ff;
			vic_pkg::VIC_FB_LO: fetch_byte = vec_lo_ff;
			default:            fetch_byte = vic_pkg::VIC_LBR_OPCODE;
		endcase
	end

	always_comb begin
		case (code_live)
			vic_pkg::VIC_SEL_VECT: rd_mux = fetch_byte;
			vic_pkg::VIC_SEL_POLL: rd_mux = cif.low_byte;
			vic_pkg::VIC_SEL_STAT: rd_mux = cif.pending;
			default:               rd_mux = vic_pkg::VIC_ZERO_BYTE;
		endcase
	end

	always_comb begin
		nxt_bus = bus_ff;
		if (pulse_a_fall) begin
			nxt_bus = cs_ok ? vic_pkg::VIC_BUS_SEL : vic_pkg::VIC_BUS_IDLE;
		end else begin
			case (bus_ff)
				vic_pkg::VIC_BUS_IDLE: nxt_bus = vic_pkg::VIC_BUS_IDLE;
				vic_pkg::VIC_BUS_SEL: begin
					if (rd_take) begin
						nxt_bus = vic_pkg::VIC_BUS_RD;
					end else if (pulse_b_rise) begin
						nxt_bus = vic_pkg::VIC_BUS_IDLE;
					end
				end
				vic_pkg::VIC_BUS_RD: begin
					if (mem_read_strobe_n) begin
						nxt_bus = vic_pkg::VIC_BUS_IDLE;
					end
				end
				default: nxt_bus = vic_pkg::VIC_BUS_IDLE;
			endcase
		end
	end

	// any other access between fetch reads restarts the three-byte sequence
	always_comb begin
		nxt_fidx = fidx_ff;
		if (fetch_done) begin
			case (fidx_ff)
				vic_pkg::VIC_FB_OP: nxt_fidx = vic_pkg::VIC_FB_HI;
				vic_pkg::VIC_FB_HI: nxt_fidx = vic_pkg::VIC_FB_LO;
				default:            nxt_fidx = vic_pkg::VIC_FB_OP;
			endcase
		end else if ((rd_done | wr_take) & (code_ff != vic_pkg::VIC_SEL_VECT | wr_take)) begin
			nxt_fidx = vic_pkg::VIC_FB_OP;
		end
	end

	// the chained controller's request also pulls our output low
	assign nxt_int_n = ~((cif.active & ctrl_ff[vic_pkg::VIC_CTRL_MIRQ]) | ~chain_in_n);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pulse_a_ff <= 1'b0;
			pulse_b_ff <= 1'b0;
			bus_ff  <= vic_pkg::VIC_BUS_IDLE;
			code_ff <= vic_pkg::VIC_SEL_NONE;
			fidx_ff <= vic_pkg::VIC_FB_OP;
		end else begin
			pulse_a_ff <= first_timing_pulse;
			pulse_b_ff <= second_timing_pulse;
			bus_ff  <= nxt_bus;
			code_ff <= rd_take ? code_live : code_ff;
			fidx_ff <= nxt_fidx;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			page_ff <= vic_pkg::VIC_PAGE_RST;
			ctrl_ff <= vic_pkg::VIC_CTRL_RST;
			mask_ff <= vic_pkg::VIC_MASK_RST;
		end else begin
			page_ff <= wr_page ? data_in : page_ff;
			ctrl_ff <= wr_ctrl ? data_in : ctrl_ff;
			mask_ff <= wr_mask ? data_in : mask_ff;
		end
	end

	// vector is frozen at the opcode byte so all three bytes agree
	always_ff @(posedge clk) begin
		if (!nrst) begin
			resp_ff    <= 1'b0;
			hit_ff     <= 1'b0;
			vec_lo_ff  <= vic_pkg::VIC_ZERO_BYTE;
			vec_num_ff <= vic_pkg::VIC_NUM_RST;
		end else if (fetch_take && fidx_ff == vic_pkg::VIC_FB_OP) begin
			resp_ff    <= chain_in_n;
			hit_ff     <= cif.active;
			vec_lo_ff  <= cif.low_byte;
			vec_num_ff <= cif.num;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			data_out_ff <= vic_pkg::VIC_DOUT_RST;
			oe_n_ff     <= 1'b1;
			int_n_ff    <= 1'b1;
		end else begin
			data_out_ff <= rd_take ? rd_mux : data_out_ff;
			if (rd_take && rd_drive) begin
				oe_n_ff <= 1'b0;
			end else if (rd_done || pulse_a_fall) begin
				oe_n_ff <= 1'b1;
			end
			int_n_ff <= nxt_int_n;
		end
	end

	assign data_out  = data_out_ff;
	assign data_oe_n = oe_n_ff;
	assign int_n     = int_n_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic rd_vect;
	assign rd_vect = (bus_ff == vic_pkg::VIC_BUS_RD) && (code_ff == vic_pkg::VIC_SEL_VECT);

	a_int_asserts: assert property (
		(cif.active && ctrl_ff[vic_pkg::VIC_CTRL_MIRQ]) |=> !int_n)
		else $error("interrupt output not low with unmasked pending");
	a_int_releases: assert property (
		(!ctrl_ff[vic_pkg::VIC_CTRL_MIRQ] && chain_in_n) |=> int_n)
		else $error("interrupt output low under master interrupt reset");
	a_opcode_byte: assert property (
		(rd_vect && fidx_ff == vic_pkg::VIC_FB_OP) |-> data_out == vic_pkg::VIC_LBR_OPCODE)
		else $error("first fetch byte is not the opcode");
	a_page_byte: assert property (
		(rd_vect && fidx_ff == vic_pkg::VIC_FB_HI) |-> data_out == page_ff)
		else $error("second fetch byte differs from page");
	a_low_byte: assert property (
		(rd_vect && fidx_ff == vic_pkg::VIC_FB_LO) |-> data_out == vec_lo_ff)
		else $error("third fetch byte differs from vector");
	a_page_write: assert property (
		wr_page |=> page_ff == $past(data_in))
		else $error("page write lost");
	a_ctrl_write: assert property (
		wr_ctrl |=> ctrl_ff == $past(data_in))
		else $error("control write lost");
	a_mask_write: assert property (
		wr_mask |=> mask_ff == $past(data_in))
		else $error("mask write lost");
	a_status_read: assert property (
		(rd_take && code_live == vic_pkg::VIC_SEL_STAT) |=> data_out == $past(cif.pending) && !data_oe_n)
		else $error("status read wrong");
	a_poll_read: assert property (
		(rd_take && code_live == vic_pkg::VIC_SEL_POLL) |=> data_out == $past(cif.low_byte))
		else $error("polling read wrong");
	a_no_select: assert property (
		(pulse_a_fall && !cs_ok) |=> bus_ff == vic_pkg::VIC_BUS_IDLE ##1 data_oe_n)
		else $error("responded without valid chip selects");
	a_unused_code: assert property (
		(rd_take && code_live == vic_pkg::VIC_SEL_NONE) |=> data_oe_n)
		else $error("unused code drove the bus");

	c_full_fetch: cover property (fetch_last && resp_ff && hit_ff);
	c_status_clear: cover property (cif.clr_all && |cif.pending);
	c_chain_defer: cover property (fetch_take && !chain_in_n);
	c_poll_read: cover property (rd_take && code_live == vic_pkg::VIC_SEL_POLL);
endmodule : vic_top
`default_nettype wire

// File: tb/vic_host_model.sv
// host processor model driving the timing pulses, selects, strobes and write data
`timescale 1ns/10ps
`default_nettype none
module vic_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe_n,
	output logic            first_timing_pulse,
	output logic            second_timing_pulse,
	output logic            chip_sel,
	output logic            chip_sel_n,
	output logic            select_addr_x,
	output logic            select_addr_y,
	output logic            mem_read_strobe_n,
	output logic            mem_write_strobe_n,
	output logic      [7:0] data_in
);
	initial begin
		first_timing_pulse = 1'h0;
		second_timing_pulse = 1'h0;
		chip_sel = 1'h0;
		chip_sel_n = 1'h1;
		select_addr_x = 1'h1;
		select_addr_y = 1'h1;
		mem_read_strobe_n = 1'h1;
		mem_write_strobe_n = 1'h1;
		data_in = 8'h00;
	end

	// one memory cycle; sel low leaves the chip selects invalid at the pulse-A fall,
	// slow holds the read strobe extra cycles as a sluggish processor would
	task automatic access(input logic sel, input vic_pkg::vic_sel_t code, input logic rd,
		input logic [7:0] wd, input int slow, output logic [7:0] rdv, output logic oev);
		@(negedge clk);
		first_timing_pulse = 1'h1;
		chip_sel = sel;
		chip_sel_n = ~sel;
		select_addr_x = 1'h1;
		select_addr_y = 1'h1;
		@(negedge clk);
		first_timing_pulse = 1'h0;
		@(negedge clk);
		{select_addr_x, select_addr_y} = code;
		second_timing_pulse = 1'h1;
		mem_read_strobe_n = ~rd;
		mem_write_strobe_n = rd;
		data_in = wd;
		repeat (1 + slow) @(negedge clk);
		second_timing_pulse = 1'h0;
		rdv = data_out;
		oev = data_oe_n;
		@(negedge clk);
		mem_read_strobe_n = 1'h1;
		mem_write_strobe_n = 1'h1;
		chip_sel = 1'h0;
		chip_sel_n = 1'h1;
		select_addr_x = 1'h1;
		select_addr_y = 1'h1;
		// released bus: the old byte must not look as if it were still valid
		data_in = ~wd;
		@(negedge clk);
	endtask : access

	// start-up order: master interrupt off, mask, page, then the full control byte
	task automatic setup(input logic [7:0] pg, input logic [7:0] ct, input logic [7:0] mk);
		logic [7:0] v;
		logic       o;
		access(1'h1, vic_pkg::VIC_SEL_POLL, 1'h0, ct & 8'hF7, 0, v, o);
		access(1'h1, vic_pkg::VIC_SEL_STAT, 1'h0, mk, 0, v, o);
		access(1'h1, vic_pkg::VIC_SEL_VECT, 1'h0, pg, 0, v, o);
		access(1'h1, vic_pkg::VIC_SEL_POLL, 1'h0, ct, 0, v, o);
	endtask : setup
endmodule : vic_host_model
`default_nettype wire

// File: tb/tb_vic_top.sv
// self-checking testbench of the vectored interrupt controller
`timescale 1ns/10ps
`default_nettype none
module tb_vic_top;
	logic       clk;
	logic       nrst;
	logic [7:0] req_n;
	logic       chain_n;
	logic       pulse_a;
	logic       pulse_b;
	logic       cs;
	logic       cs_n;
	logic       sel_x;
	logic       sel_y;
	logic       rd_n;
	logic       wr_n;
	logic [7:0] din;
	logic [7:0] dout;
	logic       oe_n;
	logic       int_n;
	int         err_total;
	int         cmp_count;
	int         i;

	vic_top dut (
		.clk(clk), .nrst(nrst), .request_inputs_n(req_n), .chain_in_n(chain_n),
		.first_timing_pulse(pulse_a), .second_timing_pulse(pulse_b), .chip_sel(cs),
		.chip_sel_n(cs_n), .select_addr_x(sel_x), .select_addr_y(sel_y),
		.mem_read_strobe_n(rd_n), .mem_write_strobe_n(wr_n), .data_in(din),
		.data_out(dout), .data_oe_n(oe_n), .int_n(int_n)
	);

	vic_host_model host (
		.clk(clk), .data_out(dout), .data_oe_n(oe_n), .first_timing_pulse(pulse_a),
		.second_timing_pulse(pulse_b), .chip_sel(cs), .chip_sel_n(cs_n),
		.select_addr_x(sel_x), .select_addr_y(sel_y), .mem_read_strobe_n(rd_n),
		.mem_write_strobe_n(wr_n), .data_in(din)
	);

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// read that must be answered on the bus
	task automatic rd(input vic_pkg::vic_sel_t c, input logic [7:0] exp, input int s);
		logic [7:0] v;
		logic       o;
		host.access(1'h1, c, 1'h1, 8'h00, s, v, o);
		chk({7'h00, o}, 8'h00);
		chk(v, exp);
	endtask : rd

	// read that the device must leave undriven
	task automatic nodrv(input logic sel, input vic_pkg::vic_sel_t c);
		logic [7:0] v;
		logic       o;
		host.access(sel, c, 1'h1, 8'h00, 0, v, o);
		chk({7'h00, o}, 8'h01);
	endtask : nodrv

	task automatic wr(input vic_pkg::vic_sel_t c, input logic [7:0] val);
		logic [7:0] v;
		logic       o;
		host.access(1'h1, c, 1'h0, val, 0, v, o);
		chk({7'h00, o}, 8'h01);
	endtask : wr

	task automatic fetch(input logic [7:0] pg, input logic [7:0] lo);
		rd(vic_pkg::VIC_SEL_VECT, vic_pkg::VIC_LBR_OPCODE, 0);
		rd(vic_pkg::VIC_SEL_VECT, pg, 1);
		rd(vic_pkg::VIC_SEL_VECT, lo, 0);
	endtask : fetch

	// falling edges on the chosen request lines, released two cycles later
	task automatic irq(input logic [7:0] m);
		@(negedge clk);
		req_n = ~m;
		repeat (2) @(negedge clk);
		req_n = 8'hFF;
	endtask : irq

	// int_n is registered behind the latch, so give it three cycles to settle
	task automatic int_is(input logic e);
		repeat (3) @(negedge clk);
		chk({7'h00, int_n}, {7'h00, e});
	endtask : int_is

	initial begin
		#200000;
		err_total++;
		report_and_stop();
	end

	initial begin
		err_total = 0;
		cmp_count = 0;
		nrst = 1'h0;
		req_n = 8'hFF;
		chain_n = 1'h1;
		repeat (10) @(negedge clk);
		nrst = 1'h1;
		chk(dout, vic_pkg::VIC_DOUT_RST);
		chk({6'h00, oe_n, int_n}, 8'h03);
		host.setup(8'h84, 8'hCE, 8'h00);
		rd(vic_pkg::VIC_SEL_STAT, 8'h00, 0);
		irq(8'h10);
		int_is(1'h0);
		rd(vic_pkg::VIC_SEL_POLL, 8'hE0, 0);
		rd(vic_pkg::VIC_SEL_STAT, 8'h10, 2);
		rd(vic_pkg::VIC_SEL_STAT, 8'h00, 0);
		int_is(1'h1);
		irq(8'h10);
		nodrv(1'h1, vic_pkg::VIC_SEL_NONE);
		wr(vic_pkg::VIC_SEL_NONE, 8'h55);
		fetch(8'h84, 8'hE0);
		int_is(1'h1);
		irq(8'h02);
		nodrv(1'h0, vic_pkg::VIC_SEL_STAT);
		int_is(1'h0);
		rd(vic_pkg::VIC_SEL_STAT, 8'h02, 0);
		irq(8'h20);
		for (i = 0; i < 4; i++) begin
			wr(vic_pkg::VIC_SEL_POLL, 8'hAC | i[7:0]);
			rd(vic_pkg::VIC_SEL_POLL, (8'hAC & (8'hFF << (i + 4))) | (8'h05 << (i + 1)), 0);
		end
		rd(vic_pkg::VIC_SEL_STAT, 8'h20, 0);
		wr(vic_pkg::VIC_SEL_STAT, 8'h80);
		wr(vic_pkg::VIC_SEL_VECT, 8'h3C);
		wr(vic_pkg::VIC_SEL_POLL, 8'hCE);
		irq(8'hC4);
		rd(vic_pkg::VIC_SEL_POLL, 8'hF0, 0);
		fetch(8'h3C, 8'hF0);
		rd(vic_pkg::VIC_SEL_POLL, 8'hD0, 0);
		int_is(1'h0);
		wr(vic_pkg::VIC_SEL_STAT, 8'hFF);
		int_is(1'h1);
		wr(vic_pkg::VIC_SEL_POLL, 8'hCA);
		int_is(1'h0);
		wr(vic_pkg::VIC_SEL_POLL, 8'hC6);
		int_is(1'h1);
		rd(vic_pkg::VIC_SEL_STAT, 8'h84, 0);
		wr(vic_pkg::VIC_SEL_POLL, 8'hCE);
		wr(vic_pkg::VIC_SEL_STAT, 8'h00);
		@(negedge clk);
		chain_n = 1'h0;
		int_is(1'h0);
		irq(8'h08);
		for (i = 0; i < 3; i++) begin
			nodrv(1'h1, vic_pkg::VIC_SEL_VECT);
		end
		@(negedge clk);
		chain_n = 1'h1;
		rd(vic_pkg::VIC_SEL_POLL, 8'hD8, 0);
		fetch(8'h3C, 8'hD8);
		int_is(1'h1);
		report_and_stop();
	end
endmodule : tb_vic_top
`default_nettype wire
